/* common/sa_dl_pkg.sv */
// Shared constants and carrier types for the E1 transmit Sa data link selector
package sa_dl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] SYNC_MUX_IDX      = 12'h109;  // Data link source field lives here
    localparam logic [11:0] DL_SELECT_IDX     = 12'h10A;  // tx_sa_datalink_select
    localparam logic [11:0] SA_INSERT_SEL_IDX = 12'h130;  // Per-bit insertion select
    localparam logic [11:0] STATUS_IDX        = 12'h140;  // Block status; a write with byte lane 0 enabled clears it
    localparam int          BYTE_SHIFT        = 2;        // Index to byte address

    // Reset values
    localparam logic [7:0] SYNC_MUX_RST      = 8'h00;
    localparam logic [7:0] DL_SELECT_RST     = 8'h00;
    localparam logic [7:0] SA_INSERT_SEL_RST = 8'h00;

    // Field positions
    localparam int DATALINK_SOURCE_FIELD_LSB = 2;                   // Source field bits 3..2
    localparam int DATALINK_SOURCE_FIELD_MSB = 3;
    localparam int SA_LO_BIT = 3;                   // Sa4 sits at bit 3
    localparam int SA_HI_BIT = 7;                   // Sa8 sits at bit 7
    localparam int SA4_BIT   = 3;
    localparam int SA5_BIT   = 4;
    localparam int SA6_BIT   = 5;
    localparam int SA7_BIT   = 6;
    localparam int SA8_BIT   = 7;

    // Data link source encodings
    typedef enum logic [1:0] {
        DATALINK_SOURCE_FIELD_SERIAL = 2'b00,
        DATALINK_SOURCE_FIELD_HDLC   = 2'b01,
        DATALINK_SOURCE_FIELD_OTHER2 = 2'b10,
        DATALINK_SOURCE_FIELD_OTHER3 = 2'b11
    } dl_source_e;

    // Insertion select value meaning serial input
    localparam logic INSERT_FROM_SERIAL = 1'b0;
    localparam logic SA_DISABLED_LEVEL  = 1'b1;     // Forced level of a disabled Sa

    // FIFO sizing
    localparam int DL_FIFO_DEPTH = 16;
    localparam int DL_FIFO_WIDTH = 1;

    // One bit of the outbound E1 stream with its position
    typedef struct packed {
        logic       data;       // Line bit value
        logic       ts0;        // Bit belongs to timeslot 0
        logic       nfas;       // Frame is a non-FAS frame
        logic [2:0] bit_pos;    // Bit number within the timeslot
    } tx_bit_s;

    // Wishbone request bundle
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [13:0] adr;
        logic [31:0] dat;
    } wb_req_s;

endpackage : sa_dl_pkg

/* core/e1_tx_sa_bit_datalink_select.sv */
// E1 transmit Sa bit data link selector with its Wishbone registers
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module e1_tx_sa_bit_datalink_select #(
    parameter int FIFO_DEPTH = sa_dl_pkg::DL_FIFO_DEPTH,
    parameter int FIFO_WIDTH = sa_dl_pkg::DL_FIFO_WIDTH
) (
    // Clock and reset
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    // Wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [13:0]         wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // HDLC controller data link bits
    input  wire logic                hdlc_bit_i,
    input  wire logic                hdlc_valid_i,
    output logic                     hdlc_ready_o,
    // Outbound stream from the frame generator
    input  wire sa_dl_pkg::tx_bit_s  tx_bit_i,
    input  wire logic                tx_valid_i,
    // Outbound stream toward the line
    output sa_dl_pkg::tx_bit_s       tx_bit_o,
    output logic                     tx_valid_o
);

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // Wishbone request gathered into one bundle
    sa_dl_pkg::wb_req_s req;
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // Byte address of each register
    function automatic logic [13:0] byte_addr(input logic [11:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

    // Software-visible state
    logic [7:0]  sync_mux_r;        // Holds the data link source field
    logic [7:0]  dl_select_r;       // Per-Sa data link enables
    logic [7:0]  sa_insert_sel_r;   // Per-Sa insertion select
    logic [15:0] inserted_cnt_r;    // HDLC bits placed on the line
    logic        underrun_r;        // Qualifying slot found the FIFO empty
    logic [31:0] rd_data_r;         // Registered read data
    logic        ack_r;             // Registered acknowledge

    // Address decode
    wire hit_mux    = (req.adr == byte_addr(sa_dl_pkg::SYNC_MUX_IDX));
    wire hit_dlsel  = (req.adr == byte_addr(sa_dl_pkg::DL_SELECT_IDX));
    wire hit_inssel = (req.adr == byte_addr(sa_dl_pkg::SA_INSERT_SEL_IDX));
    wire hit_status = (req.adr == byte_addr(sa_dl_pkg::STATUS_IDX));

    // A request is answered once, one cycle after it appears
    wire access  = req.cyc & req.stb & ~ack_r;
    wire wr_low  = access & req.we & req.sel[0];

    // Write strobe per register; unmapped writes are dropped
    wire wr_mux    = wr_low & hit_mux;
    wire wr_dlsel  = wr_low & hit_dlsel;
    wire wr_inssel = wr_low & hit_inssel;
    wire clr_stat  = wr_low & hit_status;   // Any write to the status register with byte lane 0 enabled clears the status

    // FIFO between HDLC controller and the Sa slots
    logic            fifo_bit;
    logic            fifo_valid;
    logic [LW-1:0]   fifo_level;

    // Field views
    wire sa_dl_pkg::dl_source_e dl_src =
        sa_dl_pkg::dl_source_e'(sync_mux_r[sa_dl_pkg::DATALINK_SOURCE_FIELD_MSB:sa_dl_pkg::DATALINK_SOURCE_FIELD_LSB]);
    wire hdlc_source = (dl_src == sa_dl_pkg::DATALINK_SOURCE_FIELD_HDLC);

    // Position decode of the incoming bit
    wire [2:0] pos      = tx_bit_i.bit_pos;
    wire       sa_slot  = tx_bit_i.ts0 & tx_bit_i.nfas
                        & (pos >= 3'(sa_dl_pkg::SA_LO_BIT))
                        & (pos <= 3'(sa_dl_pkg::SA_HI_BIT));
    // Enable bit index equals the bit position, Sa8 on 7 down to Sa4 on 3
    wire       sa_en    = dl_select_r[pos];
    wire       from_ser = (sa_insert_sel_r[pos] == sa_dl_pkg::INSERT_FROM_SERIAL);

    // Slot classes
    wire force_one  = sa_slot & ~sa_en & from_ser;
    wire dl_slot    = sa_slot & sa_en & from_ser & hdlc_source;
    // Each qualifying slot with the FIFO not empty takes the next FIFO bit as the stream arrives,
    // so Sa4 is filled before Sa8 within one frame
    wire take_hdlc  = tx_valid_i & dl_slot & fifo_valid;
    wire starved    = tx_valid_i & dl_slot & ~fifo_valid;

    // Value sent on the line for this bit
    logic out_data;
    assign out_data = force_one ? sa_dl_pkg::SA_DISABLED_LEVEL
                    : take_hdlc ? fifo_bit
                    : starved   ? sa_dl_pkg::SA_DISABLED_LEVEL       // Idle ones on underrun
                    : tx_bit_i.data;                                 // Others pass untouched

    // Read mux; the configuration registers read zero above the byte
    // Level sits in bits 16..12, underrun in 11, count low bits in 10..0
    wire [31:0] status_word = {15'h0000, LW'(fifo_level), underrun_r,
                               inserted_cnt_r[10:0]} ;
    wire [31:0] rd_mux = hit_mux    ? {24'h000000, sync_mux_r}
                       : hit_dlsel  ? {24'h000000, dl_select_r}
                       : hit_inssel ? {24'h000000, sa_insert_sel_r}
                       : hit_status ? status_word
                       : 32'h00000000;

    // FIFO instance; its ready stalls the HDLC controller
    sa_dl_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i),
        .in_data_i   (hdlc_bit_i),
        .in_valid_i  (hdlc_valid_i),
        .in_ready_o  (hdlc_ready_o),
        .out_data_o  (fifo_bit),
        .out_valid_o (fifo_valid),
        .out_ready_i (take_hdlc),
        .level_o     (fifo_level)
    );

    // Bus answer: ack one cycle after the request, dropped the next
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            ack_r     <= 1'b0;
            rd_data_r <= 32'h00000000;
        end
        else
        begin
            ack_r     <= access;
            rd_data_r <= access ? rd_mux : rd_data_r;
        end
    end

    // Configuration registers
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            sync_mux_r      <= sa_dl_pkg::SYNC_MUX_RST;
            dl_select_r     <= sa_dl_pkg::DL_SELECT_RST;
            sa_insert_sel_r <= sa_dl_pkg::SA_INSERT_SEL_RST;
        end
        else
        begin
            if (wr_mux)    sync_mux_r      <= req.dat[7:0];
            if (wr_dlsel)  dl_select_r     <= req.dat[7:0];
            if (wr_inssel) sa_insert_sel_r <= req.dat[7:0];
        end
    end

    // Status; a new event in the clearing cycle wins over the clear
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            inserted_cnt_r <= 16'h0000;
            underrun_r     <= 1'b0;
        end
        else
        begin
            if (take_hdlc)     inserted_cnt_r <= clr_stat ? 16'h0001 : inserted_cnt_r + 16'h0001;
            else if (clr_stat) inserted_cnt_r <= 16'h0000;
            underrun_r <= starved | (underrun_r & ~clr_stat);
        end
    end

    // Outbound stream register, one cycle of latency
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            tx_bit_o   <= '0;
            tx_valid_o <= 1'b0;
        end
        else
        begin
            tx_valid_o <= tx_valid_i;
            if (tx_valid_i)
            begin
                tx_bit_o      <= tx_bit_i;
                tx_bit_o.data <= out_data;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_data_r;

endmodule : e1_tx_sa_bit_datalink_select

/* core/sa_dl_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sa_dl_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Drain side
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    // Fill level
    output logic      [$clog2(DEPTH):0] level_o
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];    // Storage in flops
    logic [AW-1:0]    wr_ptr_r;         // Next slot to write
    logic [AW-1:0]    rd_ptr_r;         // Oldest slot
    logic [AW:0]      count_r;          // Words held
    logic [AW:0]      count_nxt;
    logic             ready_r;          // Registered not-full

    wire push = in_valid_i & ready_r;
    wire pop  = out_ready_i & (count_r != '0);

    // Count after this cycle's push and pop
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    assign in_ready_o  = ready_r;
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign level_o     = count_r;

    // Pointer wrap shared by both ends
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_SLOT) ? '0 : p + AW'(1);
    endfunction : bump

    // Pointers and count; ready follows the next count so full is honest
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            ready_r  <= 1'b0;
        end
        else
        begin
            if (push) wr_ptr_r <= bump(wr_ptr_r);
            if (pop)  rd_ptr_r <= bump(rd_ptr_r);
            count_r <= count_nxt;
            ready_r <= (count_nxt != FULL_LEVEL);
        end
    end

    // Data store, no reset needed
    always_ff @(posedge clock_i)
    begin
        if (push) mem_r[wr_ptr_r] <= in_data_i;
    end

endmodule : sa_dl_fifo

/* verification/e1_line_sink.sv */
// Line side model that takes every outbound bit and counts them
`timescale 1ns/100ps
module e1_line_sink (
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               rstn_i,
    // Outbound stream from the selector
    input  wire sa_dl_pkg::tx_bit_s tx_bit_i,
    input  wire logic               tx_valid_i,
    // Bits received so far
    output logic [15:0]             count_o
);
    // The line never stalls, so every strobe is one bit on the wire
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            count_o <= 16'h0000;
        else if (tx_valid_i)
            count_o <= count_o + 16'h0001;
    end
endmodule : e1_line_sink

/* verification/e1_tx_sa_bit_datalink_select_bench.sv */
// Self-checking bench for the Sa data link selector
`timescale 1ns/100ps
module e1_tx_sa_bit_datalink_select_bench;
    logic clock_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;  // Clock, reset, bus
    logic hdlc_bit_i, hdlc_valid_i, hdlc_ready_o, tx_valid_i, tx_valid_o;  // Link, stream
    logic [3:0]  wb_sel_i;    // Byte lanes
    logic [13:0] wb_adr_i;    // Byte address
    logic [31:0] wb_dat_i, wb_dat_o;
    sa_dl_pkg::tx_bit_s tx_bit_i, tx_bit_o;
    logic [15:0] line_count;  // Bits seen by the line model
    int bad_count, compares, sent;
    e1_tx_sa_bit_datalink_select dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .hdlc_bit_i(hdlc_bit_i), .hdlc_valid_i(hdlc_valid_i), .hdlc_ready_o(hdlc_ready_o),
        .tx_bit_i(tx_bit_i), .tx_valid_i(tx_valid_i), .tx_bit_o(tx_bit_o), .tx_valid_o(tx_valid_o));
    e1_line_sink line_u (.clock_i(clock_i), .rstn_i(rstn_i), .tx_bit_i(tx_bit_o),
        .tx_valid_i(tx_valid_o), .count_o(line_count));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic give_verdict();
        $display("Compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Classic single cycle; the request stands until ack is sampled high
    task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d,
                      input logic [3:0] sl, output logic [31:0] rd);
        int n = 0;
        @(posedge clock_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, sl};
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic cfg(input logic [7:0] en, input logic [7:0] sl, input logic [1:0] src);
        logic [31:0] r;
        wb(1'b1, sa_dl_pkg::SYNC_MUX_IDX, {4'h0, src, 2'b00}, 4'hF, r);
        wb(1'b1, sa_dl_pkg::DL_SELECT_IDX, en, 4'hF, r);
        wb(1'b1, sa_dl_pkg::SA_INSERT_SEL_IDX, sl, 4'hF, r);
    endtask : cfg
    // Push n link bits back to back, lowest first
    task automatic push(input logic [15:0] p, input int n);
        @(posedge clock_i);
        hdlc_valid_i <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            hdlc_bit_i <= p[i];
            @(posedge clock_i);
        end
        hdlc_valid_i <= 1'b0;
    endtask : push
    // One timeslot 0 bit through the block; seen is the line bit
    task automatic bit_out(input logic nf, input int pos, input logic d, output logic [31:0] s);
        @(posedge clock_i);
        tx_valid_i <= 1'b1;
        tx_bit_i <= '{data: d, ts0: 1'b1, nfas: nf, bit_pos: 3'(pos)};
        @(posedge clock_i);
        tx_valid_i <= 1'b0;
        #1;
        s = {31'h0, tx_bit_o.data};
        sent++;
    endtask : bit_out
    task automatic t_regs();
        logic [31:0] r;
        wb(1'b0, sa_dl_pkg::DL_SELECT_IDX, 8'h00, 4'hF, r);
        check(r, 32'h0, "enable reset");
        wb(1'b1, sa_dl_pkg::DL_SELECT_IDX, 8'hFF, 4'hF, r);
        wb(1'b1, sa_dl_pkg::DL_SELECT_IDX, 8'h00, 4'hE, r);  // Lane 0 off, ignored
        wb(1'b0, sa_dl_pkg::DL_SELECT_IDX, 8'h00, 4'hF, r);
        check(r, 32'hFF, "enable readback");
        wb(1'b0, 12'h001, 8'h00, 4'hF, r);
        check(r, 32'h0, "unmapped read");
    endtask : t_regs
    // Disabled serial slots send one, other bits pass
    task automatic t_disabled();
        logic [31:0] s;
        cfg(8'h00, 8'h00, 2'b01);
        for (int p = 3; p < 8; p++)
        begin
            bit_out(1'b1, p, 1'b0, s);
            check(s, 32'h1, "disabled slot");
        end
        bit_out(1'b1, 2, 1'b0, s);
        check(s, 32'h0, "non Sa bit");
        bit_out(1'b0, 5, 1'b0, s);
        check(s, 32'h0, "FAS frame bit");
    endtask : t_disabled
    // Each enable bit claims only its own slot for link bits
    task automatic t_per_bit();
        logic [31:0] s;
        for (int k = 3; k < 8; k++)
        begin
            cfg(8'h01 << k, 8'h00, 2'b01);
            push(16'h0000, 1);
            for (int p = 3; p < 8; p++)
            begin
                bit_out(1'b1, p, 1'b1, s);
                check(s, (p == k) ? 32'h0 : 32'h1, "per bit");
            end
        end
    endtask : t_per_bit
    // Register select and other sources leave the serial bit alone
    task automatic t_pass();
        logic [31:0] s;
        cfg(8'hF8, 8'hF8, 2'b01);
        for (int p = 3; p < 8; p++)
        begin
            bit_out(1'b1, p, 1'b0, s);
            check(s, 32'h0, "register select");
        end
        for (int c = 0; c < 4; c++)
        begin
            if (c == 1) continue;
            cfg(8'hF8, 8'h00, 2'(c));
            bit_out(1'b1, 3 + c, 1'b0, s);
            check(s, 32'h0, "other source");
        end
    endtask : t_pass
    // Fill to refusal, drain in ascending slots, then run empty
    task automatic t_fifo();
        logic [31:0] s;
        cfg(8'hF8, 8'h00, 2'b01);
        wb(1'b1, sa_dl_pkg::STATUS_IDX, 8'h00, 4'hF, s);  // Clear count and underrun
        push(16'hA5C3, 16);
        push(16'h0000, 1);  // Refused while full
        #1;
        check({31'h0, hdlc_ready_o}, 32'h0, "full ready");
        for (int i = 0; i < 16; i++)
        begin
            bit_out(1'b1, 3 + i % 5, ~16'hA5C3 >> i, s);
            check(s, {31'h0, 1'(16'hA5C3 >> i)}, "drain order");
        end
        bit_out(1'b1, 3, 1'b0, s);
        check(s, 32'h1, "empty slot");
        check({31'h0, hdlc_ready_o}, 32'h1, "ready again");
        wb(1'b0, sa_dl_pkg::STATUS_IDX, 8'h00, 4'hF, s);
        check(s, 32'h00000810, "status count");
        @(posedge clock_i);
        #1;
        check({16'h0, line_count}, 32'(sent), "line count");
    endtask : t_fifo
    // Free-running clock
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Watchdog well beyond the expected run
    initial
    begin
        #50000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, hdlc_bit_i, hdlc_valid_i, tx_valid_i} = 7'h00;
        {wb_sel_i, wb_adr_i, wb_dat_i, tx_bit_i} = '0;
        {bad_count, compares, sent} = {32'h0, 32'h0, 32'h0};
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_regs();
        t_disabled();
        t_per_bit();
        t_pass();
        t_fifo();
        give_verdict();
    end
endmodule : e1_tx_sa_bit_datalink_select_bench

/* verification/e1_tx_sa_monitor.sv */
// Port level checker for the Sa data link selector
`timescale 1ns/100ps
module e1_tx_sa_monitor #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock, reset and bus
    input wire logic clock_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    // Data link and stream
    input wire logic hdlc_bit_i, hdlc_valid_i, hdlc_ready_o, tx_valid_i, tx_valid_o,
    input wire sa_dl_pkg::tx_bit_s tx_bit_i, tx_bit_o
);
    logic [7:0] en_r;   // Shadow of the enables
    logic [7:0] sel_r;  // Shadow of the insert selects
    logic [1:0] src_r;  // Shadow of the source field
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire slot = tx_valid_i & tx_bit_i.ts0 & tx_bit_i.nfas & (tx_bit_i.bit_pos >= 3'h3);
    wire ena = en_r[tx_bit_i.bit_pos];
    wire ser = ~sel_r[tx_bit_i.bit_pos];
    // Shadows follow accepted writes so slot checks know the setup
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            en_r  <= 8'h00;
            sel_r <= 8'h00;
            src_r <= 2'h0;
        end
        else if (wr)
        begin
            if (wb_adr_i == 14'h0428) en_r <= wb_dat_i[7:0];
            if (wb_adr_i == 14'h04C0) sel_r <= wb_dat_i[7:0];
            if (wb_adr_i == 14'h0424) src_r <= wb_dat_i[3:2];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_valid_delay: assert property (tx_valid_i |=> tx_valid_o) else $error("stream bit lost");
    a_no_spurious: assert property (!tx_valid_i |=> !tx_valid_o) else $error("spurious bit");
    a_frame_kept: assert property (tx_valid_i |=> tx_bit_o[4:0] == $past(tx_bit_i[4:0]))
        else $error("bit position changed");
    a_plain_pass: assert property (
        tx_valid_i && !slot |=> tx_bit_o.data == $past(tx_bit_i.data))
        else $error("non Sa bit altered");
    a_disabled_one: assert property (slot && !ena && ser |=> tx_bit_o.data)
        else $error("disabled Sa not one");
    a_select_pass: assert property (
        slot && !ser |=> tx_bit_o.data == $past(tx_bit_i.data))
        else $error("register select altered bit");
    a_source_pass: assert property (
        slot && ena && ser && src_r != 2'b01
        |=> tx_bit_o.data == $past(tx_bit_i.data)) else $error("non HDLC source used");
    a_ready_release: assert property ($rose(rstn_i) |=> hdlc_ready_o) else $error("not ready");
    // Main scenarios reached
    c_hdlc_slot: cover property (slot && ena && ser && src_r == 2'b01);
    c_fifo_full: cover property (!hdlc_ready_o);
    c_bus_read: cover property (wb_ack_o && !wb_we_i);
endmodule : e1_tx_sa_monitor
bind e1_tx_sa_bit_datalink_select e1_tx_sa_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .hdlc_bit_i(hdlc_bit_i),
    .hdlc_valid_i(hdlc_valid_i), .hdlc_ready_o(hdlc_ready_o), .tx_valid_i(tx_valid_i),
    .tx_valid_o(tx_valid_o), .tx_bit_i(tx_bit_i), .tx_bit_o(tx_bit_o));
